// *** logic/hssc_core.sv ***
// High-side switch control: channel selection, PWM, timers, protection and registers
`timescale 1ns/100ps
`include "hssc_map.svh"
// Notes on behaviour
// - Output follows direct bit, timer or PWM.
// - Configuration writes accepted only in Normal mode.
// - Stop/Sleep keep configuration, ignore changes.
// - Restart or Fail-Safe forces all outputs off.
// - OV/UV shutdown, each separately enabled.
// - Overcurrent on active output turns it off.
// - Open load evaluated only while output on.
// - Recovery setting decides return after OV/UV.
// - PWM and timers from internal time base.
// - Overcurrent clears field, sets latched flag.
// - Without recovery bit, outputs off, fields cleared.
// - Two 8-bit PWMs, 200 or 400 Hz.
// - Open load sets latched flag, output stays.
module hssc_core #(
    parameter int N_CH          = 4,
    parameter int TMR_PERIOD_CYC = `HSSC_TMR_PERIOD_CYC,
    parameter int TMR_ON_CYC     = `HSSC_TMR_ON_CYC
) (
    input  wire logic                i_mclk,
    input  wire logic                i_sys_rst,
    input  wire hssc_pkg::hssc_mode_t i_mode,
    input  wire hssc_pkg::hssc_req_t  i_req,
    input  wire hssc_pkg::hssc_sense_t i_sense,
    output logic [7:0]               o_rdata,
    output logic [N_CH-1:0]          o_switched_output_n,
    output logic                     o_irq
);
    import hssc_pkg::*;

    // Elaboration-time guards: the map packs four fields, timer 2 must end inside the period
    if (N_CH != 4) begin : g_bad_ch
        $error("hssc_core supports exactly four channels");
    end
    if (TMR_ON_CYC < 1 || TMR_ON_CYC > TMR_PERIOD_CYC / 2) begin : g_bad_tmr
        $error("bad timer counts");
    end

    // ****************************************************************
    // Input synchronisers for the analog comparators
    // ****************************************************************
    hssc_sense_t sense_meta;
    hssc_sense_t sense_sync;

    always_ff @(posedge i_mclk) begin
        sense_meta <= i_sense;
        sense_sync <= sense_meta;
    end

    // ****************************************************************
    // Mode decoding
    // ****************************************************************
    wire mode_normal = (i_mode == HSSC_MODE_NORMAL);
    wire mode_forced_off = (i_mode == HSSC_MODE_RESTART) || (i_mode == HSSC_MODE_FAILSAFE);
    // Config is frozen outside Normal; Stop/Sleep keep applying the last values
    wire cfg_wr = i_req.wr && mode_normal;

    wire wr_ctrl_a  = cfg_wr && (i_req.addr == `HSSC_ADDR_CTRL_A);
    wire wr_ctrl_b  = cfg_wr && (i_req.addr == `HSSC_ADDR_CTRL_B);
    wire wr_supply  = cfg_wr && (i_req.addr == `HSSC_ADDR_SUPPLY_CFG);
    wire wr_pwm1    = cfg_wr && (i_req.addr == `HSSC_ADDR_PWM1);
    wire wr_pwm2    = cfg_wr && (i_req.addr == `HSSC_ADDR_PWM2);
    wire wr_freq    = cfg_wr && (i_req.addr == `HSSC_ADDR_PWM_FREQ);
    // Flag clears and the interrupt mask write work in every mode; they are not configuration
    wire wr_oc_stat = i_req.wr && (i_req.addr == `HSSC_ADDR_OC_STAT);
    wire wr_ol_stat = i_req.wr && (i_req.addr == `HSSC_ADDR_OL_STAT);
    wire wr_irq_st  = i_req.wr && (i_req.addr == `HSSC_ADDR_IRQ_STAT);
    wire wr_irq_msk = i_req.wr && (i_req.addr == `HSSC_ADDR_IRQ_MASK);

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic [2:0] ch_cfg [N_CH];
    logic [7:0] supply_cfg;
    logic [7:0] pwm_duty [2];
    logic [1:0] pwm_fast;
    logic [3:0] oc_flag;
    logic [3:0] ol_flag;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;

    // ****************************************************************
    // Supply fault detection
    // ****************************************************************
    wire ov_shut = sense_sync.supply_ov && supply_cfg[`HSSC_BIT_OV_SD_EN];
    wire uv_shut = sense_sync.supply_uv && supply_cfg[`HSSC_BIT_UV_SD_EN];
    wire supply_shut = ov_shut || uv_shut;
    logic supply_shut_d;
    wire supply_shut_rise = supply_shut && !supply_shut_d;
    wire rec_en = supply_cfg[`HSSC_BIT_REC_EN];
    // Without recovery, fields are wiped at shutdown so nothing returns on release
    wire supply_clear = supply_shut_rise && !rec_en;

    // ****************************************************************
    // PWM generators: shared 8-bit phase per generator, prescaled tick
    // ****************************************************************
    logic [15:0] pwm_pre [2];
    logic [7:0]  pwm_phase [2];
    logic [1:0]  pwm_level;

    for (genvar g = 0; g < 2; g++) begin : g_pwm
        wire [15:0] div = pwm_fast[g] ? 16'(`HSSC_PWM_FAST_DIV - 1)
                                      : 16'(`HSSC_PWM_SLOW_DIV - 1);
        wire pre_wrap = (pwm_pre[g] >= div);
        assign pwm_level[g] = (pwm_phase[g] < pwm_duty[g]);

        always_ff @(posedge i_mclk) begin
            if (i_sys_rst) begin
                pwm_pre[g]   <= 16'h0000;
                pwm_phase[g] <= 8'h00;
            end else begin
                pwm_pre[g]   <= pre_wrap ? 16'h0000 : pwm_pre[g] + 16'h0001;
                pwm_phase[g] <= pre_wrap ? pwm_phase[g] + 8'h01 : pwm_phase[g];
            end
        end
    end

    // ****************************************************************
    // Internal timers: short on-pulse per period, timer 2 half a period later
    // ****************************************************************
    logic [31:0] tmr_cnt;
    wire [31:0] tmr_last = 32'(TMR_PERIOD_CYC - 1);
    wire [31:0] tmr_half = 32'(TMR_PERIOD_CYC / 2);
    wire tmr1_level = (tmr_cnt < 32'(TMR_ON_CYC));
    wire tmr2_level = (tmr_cnt >= tmr_half) && (tmr_cnt < tmr_half + 32'(TMR_ON_CYC));

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            tmr_cnt <= 32'h0000_0000;
        end else begin
            tmr_cnt <= (tmr_cnt >= tmr_last) ? 32'h0000_0000 : tmr_cnt + 32'h0000_0001;
        end
    end

    // ****************************************************************
    // Per-channel source selection and protection
    // ****************************************************************
    logic [N_CH-1:0] ch_src;
    logic [N_CH-1:0] ch_on;
    logic [N_CH-1:0] oc_event;
    logic [N_CH-1:0] ol_event;
    logic [2:0]      next_cfg [N_CH];

    for (genvar c = 0; c < N_CH; c++) begin : g_ch
        always_comb begin
            case (ch_cfg[c])
                `HSSC_CFG_ON:   ch_src[c] = 1'b1;
                `HSSC_CFG_TMR1: ch_src[c] = tmr1_level;
                `HSSC_CFG_TMR2: ch_src[c] = tmr2_level;
                `HSSC_CFG_PWM1: ch_src[c] = pwm_level[0];
                `HSSC_CFG_PWM2: ch_src[c] = pwm_level[1];
                default:        ch_src[c] = 1'b0;
            endcase
        end
        assign ch_on[c] = ch_src[c] && !mode_forced_off && !supply_shut;
        assign oc_event[c] = ch_on[c] && sense_sync.overcurrent[c];
        assign ol_event[c] = ch_on[c] && sense_sync.open_load[c];

        wire [2:0] wdata_field = (c < 2) ? i_req.wdata[(c%2)*4 +: 3] : i_req.wdata[(c%2)*4 +: 3];
        wire       wr_field = (c < 2) ? wr_ctrl_a : wr_ctrl_b;
        always_comb begin
            next_cfg[c] = ch_cfg[c];
            if (wr_field) begin
                next_cfg[c] = wdata_field;
            end
            // Hardware shutdown wins over a same-cycle write
            if (oc_event[c] || supply_clear) begin
                next_cfg[c] = `HSSC_CFG_OFF;
            end
        end
        always_ff @(posedge i_mclk) begin
            if (i_sys_rst) begin
                ch_cfg[c] <= `HSSC_CFG_OFF;
            end else begin
                ch_cfg[c] <= next_cfg[c];
            end
        end
    end

    // ****************************************************************
    // Flags and interrupt: set wins over write-one-to-clear
    // ****************************************************************
    wire [3:0] irq_evt = {uv_shut && !supply_shut_d, ov_shut && !supply_shut_d,
                          |ol_event, |oc_event};
    wire [3:0] next_oc  = (oc_flag & ~(wr_oc_stat ? i_req.wdata[3:0] : 4'h0)) | oc_event;
    wire [3:0] next_ol  = (ol_flag & ~(wr_ol_stat ? i_req.wdata[3:0] : 4'h0)) | ol_event;
    wire [3:0] next_irq = (irq_stat & ~(wr_irq_st ? i_req.wdata[3:0] : 4'h0)) | irq_evt;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            supply_cfg    <= `HSSC_SUPPLY_RST;
            pwm_duty[0]   <= `HSSC_PWM_RST;
            pwm_duty[1]   <= `HSSC_PWM_RST;
            pwm_fast      <= 2'h0;
            oc_flag       <= 4'h0;
            ol_flag       <= 4'h0;
            irq_stat      <= 4'h0;
            irq_mask      <= 4'h0;
            supply_shut_d <= 1'b0;
        end else begin
            if (wr_supply) supply_cfg <= {5'h00, i_req.wdata[2:0]};
            if (wr_pwm1) pwm_duty[0] <= i_req.wdata;
            if (wr_pwm2) pwm_duty[1] <= i_req.wdata;
            if (wr_freq) pwm_fast <= i_req.wdata[1:0];
            if (wr_irq_msk) irq_mask <= i_req.wdata[3:0];
            oc_flag       <= next_oc;
            ol_flag       <= next_ol;
            irq_stat      <= next_irq;
            supply_shut_d <= supply_shut;
        end
    end

    // ****************************************************************
    // Read port and outputs
    // ****************************************************************
    logic [7:0] rd_mux;
    always_comb begin
        case (i_req.addr)
            `HSSC_ADDR_CTRL_A:     rd_mux = {1'b0, ch_cfg[1], 1'b0, ch_cfg[0]};
            `HSSC_ADDR_CTRL_B:     rd_mux = {1'b0, ch_cfg[3], 1'b0, ch_cfg[2]};
            `HSSC_ADDR_SUPPLY_CFG: rd_mux = {2'h0, sense_sync.supply_uv, sense_sync.supply_ov,
                                             1'b0, supply_cfg[2:0]};
            `HSSC_ADDR_PWM1:       rd_mux = pwm_duty[0];
            `HSSC_ADDR_PWM2:       rd_mux = pwm_duty[1];
            `HSSC_ADDR_PWM_FREQ:   rd_mux = {6'h00, pwm_fast};
            `HSSC_ADDR_OC_STAT:    rd_mux = {4'h0, oc_flag};
            `HSSC_ADDR_OL_STAT:    rd_mux = {4'h0, ol_flag};
            `HSSC_ADDR_IRQ_STAT:   rd_mux = {4'h0, irq_stat};
            `HSSC_ADDR_IRQ_MASK:   rd_mux = {4'h0, irq_mask};
            `HSSC_ADDR_OUT_STATE:  rd_mux = {4'h0, o_switched_output_n};
            default:               rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_rdata             <= 8'h00;
            o_switched_output_n <= '0;
            o_irq               <= 1'b0;
        end else begin
            o_rdata             <= i_req.rd ? rd_mux : 8'h00;
            o_switched_output_n <= ch_on;
            o_irq               <= |(next_irq & irq_mask);
        end
    end

endmodule // hssc_core

// *** shared/hssc_map.svh ***
// Register offsets, field layouts, reset values and timing counts of the switch control
`ifndef HSSC_MAP_SVH
`define HSSC_MAP_SVH

// ****************************************************************
// Register offsets (word addresses on the plain register port)
// ****************************************************************
`define HSSC_ADDR_CTRL_A      4'h0
`define HSSC_ADDR_CTRL_B      4'h1
`define HSSC_ADDR_SUPPLY_CFG  4'h2
`define HSSC_ADDR_PWM1        4'h3
`define HSSC_ADDR_PWM2        4'h4
`define HSSC_ADDR_PWM_FREQ    4'h5
`define HSSC_ADDR_OC_STAT     4'h6
`define HSSC_ADDR_OL_STAT     4'h7
`define HSSC_ADDR_IRQ_STAT    4'h8
`define HSSC_ADDR_IRQ_MASK    4'h9
`define HSSC_ADDR_OUT_STATE   4'ha

// ****************************************************************
// Output configuration codes (3-bit field per channel)
// ****************************************************************
`define HSSC_CFG_OFF    3'h0
`define HSSC_CFG_ON     3'h1
`define HSSC_CFG_TMR1   3'h2
`define HSSC_CFG_TMR2   3'h3
`define HSSC_CFG_PWM1   3'h4
`define HSSC_CFG_PWM2   3'h5

// ****************************************************************
// Supply configuration bit positions and reset values
// ****************************************************************
`define HSSC_BIT_OV_SD_EN  0
`define HSSC_BIT_UV_SD_EN  1
`define HSSC_BIT_REC_EN    2
`define HSSC_BIT_OV_FLAG   4
`define HSSC_BIT_UV_FLAG   5
`define HSSC_SUPPLY_RST    8'h07
`define HSSC_PWM_RST       8'h00

// ****************************************************************
// Interrupt status bit positions
// ****************************************************************
`define HSSC_IRQ_OC   0
`define HSSC_IRQ_OL   1
`define HSSC_IRQ_OV   2
`define HSSC_IRQ_UV   3

// ****************************************************************
// Timing: clock rate, PWM periods, timer periods
// ****************************************************************
`define HSSC_CLK_HZ        10000000
`define HSSC_PWM_SLOW_HZ   200
`define HSSC_PWM_FAST_HZ   400
`define HSSC_PWM_STEPS     256
`define HSSC_PWM_SLOW_DIV  (`HSSC_CLK_HZ / (`HSSC_PWM_SLOW_HZ * `HSSC_PWM_STEPS))
`define HSSC_PWM_FAST_DIV  (`HSSC_CLK_HZ / (`HSSC_PWM_FAST_HZ * `HSSC_PWM_STEPS))
`define HSSC_TMR_PERIOD_MS 1000
`define HSSC_TMR_ON_MS     10
`define HSSC_TMR_PERIOD_CYC (`HSSC_CLK_HZ / 1000 * `HSSC_TMR_PERIOD_MS)
`define HSSC_TMR_ON_CYC    (`HSSC_CLK_HZ / 1000 * `HSSC_TMR_ON_MS)

`endif

// *** shared/hssc_pkg.sv ***
// Types shared by the high-side switch control
package hssc_pkg;

    typedef enum logic [4:0] {
        HSSC_MODE_INIT     = 5'h01,
        HSSC_MODE_NORMAL   = 5'h02,
        HSSC_MODE_LOWPWR   = 5'h04,
        HSSC_MODE_RESTART  = 5'h08,
        HSSC_MODE_FAILSAFE = 5'h10
    } hssc_mode_t;

    // Register port request bundle
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } hssc_req_t;

    // Analog comparator results per channel plus the two supply flags (asynchronous to the clock)
    typedef struct packed {
        logic [3:0] overcurrent;
        logic [3:0] open_load;
        logic       supply_ov;
        logic       supply_uv;
    } hssc_sense_t;

endpackage

// *** tb/hssc_core_checker.sv ***
// Port-level assertions for the high-side switch control
`timescale 1ns/100ps
`include "hssc_map.svh"
module hssc_core_checker #(
    parameter int N_CH = 4
) (
    input wire logic                  i_mclk,
    input wire logic                  i_sys_rst,
    input wire hssc_pkg::hssc_mode_t  i_mode,
    input wire hssc_pkg::hssc_req_t   i_req,
    input wire hssc_pkg::hssc_sense_t i_sense,
    input wire logic [7:0]            o_rdata,
    input wire logic [N_CH-1:0]       o_switched_output_n,
    input wire logic                  o_irq
);
    import hssc_pkg::*;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    wire fault_mode = (i_mode == HSSC_MODE_RESTART) || (i_mode == HSSC_MODE_FAILSAFE);
    wire mask_off   = i_req.wr && (i_req.addr == `HSSC_ADDR_IRQ_MASK) && (i_req.wdata == 8'h00);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_fault_off: assert property (fault_mode |=> o_switched_output_n == '0)
        else $error("output on in restart or fail-safe");
    a_rdata_idle: assert property (!i_req.rd |=> o_rdata == 8'h00)
        else $error("read data outside read slot");
    a_state_read: assert property ((i_req.rd && i_req.addr == `HSSC_ADDR_OUT_STATE)
        |=> o_rdata == 8'($past(o_switched_output_n))) else $error("output state readback");
    a_unmapped_zero: assert property ((i_req.rd && i_req.addr > `HSSC_ADDR_OUT_STATE)
        |=> o_rdata == 8'h00) else $error("unmapped read not zero");
    a_irq_masked: assert property (mask_off |-> ##[1:2] !o_irq)
        else $error("interrupt high with mask cleared");
    a_oc_cut: assert property (($rose(i_sense.overcurrent[0]) && o_switched_output_n[0])
        |-> ##[1:4] !o_switched_output_n[0]) else $error("overcurrent not cut");
    a_oc_stays_off: assert property (($fell(o_switched_output_n[0]) && i_sense.overcurrent[0])
        |=> !o_switched_output_n[0] [*8]) else $error("channel back on after overcurrent");
    a_reset_clear: assert property ($fell(i_sys_rst)
        |-> (o_switched_output_n == '0) && !o_irq) else $error("outputs not clear after reset");
endmodule // hssc_core_checker

// *** tb/hssc_load_model.sv ***
// Load model: shorted or open loads and the switch supply seen by the comparators
`timescale 1ns/100ps
module hssc_load_model (
    input  wire logic             i_mclk,
    input  wire logic [3:0]       i_drive,
    input  wire logic [3:0]       i_short,
    input  wire logic [3:0]       i_open,
    input  wire logic             i_ov,
    input  wire logic             i_uv,
    output hssc_pkg::hssc_sense_t o_sense
);
    import hssc_pkg::*;
    initial o_sense = '0;
    // A short only draws current while its switch conducts; one cycle late like a real filter
    always @(posedge i_mclk) begin
        o_sense <= '{overcurrent: i_drive & i_short, open_load: i_open,
                     supply_ov: i_ov, supply_uv: i_uv};
    end
endmodule // hssc_load_model

// *** tb/tb_top.sv ***
// Self-checking bench for the high-side switch control
`timescale 1ns/100ps
`include "hssc_map.svh"
module tb_top;
    import hssc_pkg::*;
    localparam int WIN = `HSSC_PWM_SLOW_DIV * `HSSC_PWM_STEPS;
    logic        i_mclk    = 1'b0;
    logic        i_sys_rst = 1'b1;
    hssc_mode_t  mode      = HSSC_MODE_NORMAL;
    hssc_req_t   req       = '0;
    hssc_sense_t sense;
    logic [7:0]  rdata;
    logic [3:0]  outs;
    logic        irq;
    logic [3:0]  short_m   = '0;
    logic [3:0]  open_m    = '0;
    logic        ov        = 1'b0;
    logic        uv        = 1'b0;
    logic        counting  = 1'b0;
    int          n_errors  = 0;
    int          check_count = 0;
    int          cycles    = 0;
    int          hi_cnt [4];
    int          rise_cnt [2] = '{0, 0};
    logic [3:0]  outs_d    = '0;
    logic        edge_on   = 1'b0;
    hssc_mode_t  fm [2]    = '{HSSC_MODE_RESTART, HSSC_MODE_FAILSAFE};

    always #50 i_mclk = ~i_mclk;

    hssc_core #(.N_CH(4), .TMR_PERIOD_CYC(100), .TMR_ON_CYC(10)) i_hssc_core (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_mode(mode), .i_req(req), .i_sense(sense),
        .o_rdata(rdata), .o_switched_output_n(outs), .o_irq(irq));
    hssc_load_model i_hssc_load_model (.i_mclk(i_mclk), .i_drive(outs), .i_short(short_m),
        .i_open(open_m), .i_ov(ov), .i_uv(uv), .o_sense(sense));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_mclk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge i_mclk);
        req <= '0;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rchk(input string name, input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_mclk);
        req <= '0;
        // Read data stand for one cycle; taken at the next edge before it is cleared
        @(posedge i_mclk);
        chk(name, exp, rdata);
    endtask
    task automatic near(input string name, input int exp, input int got);
        check_count++;
        if (got < exp - 300 || got > exp + 300) begin
            n_errors++;
            $display("ERROR %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    // Timeout cuts a hang short; PWM window counters ride on the same edge
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (counting) for (int c = 0; c < 4; c++) hi_cnt[c] <= hi_cnt[c] + int'(outs[c]);
        outs_d <= outs;
        // Rising edges on the two PWM channels tell the periods apart
        if (edge_on) for (int c = 0; c < 2; c++)
            rise_cnt[c] <= rise_cnt[c] + int'(outs[c + 2] && !outs_d[c + 2]);
        if (cycles == 60000) begin
            n_errors = n_errors + 1;
            complete_run();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        step(4);
        i_sys_rst <= 1'b0;
        rchk("supply_cfg", `HSSC_ADDR_SUPPLY_CFG, `HSSC_SUPPLY_RST);
        rchk("unmapped", 4'hf, 8'h00);
        wr(`HSSC_ADDR_CTRL_A, 8'h11);
        wr(`HSSC_ADDR_CTRL_B, 8'h11);
        rchk("out_state", `HSSC_ADDR_OUT_STATE, 8'h0f);
        mode <= HSSC_MODE_LOWPWR;
        wr(`HSSC_ADDR_CTRL_A, 8'h00);
        step(2);
        chk("lowpwr_out", 8'h0f, {4'h0, outs});
        rchk("ctrl_frozen", `HSSC_ADDR_CTRL_A, 8'h11);
        mode <= HSSC_MODE_INIT;
        wr(`HSSC_ADDR_CTRL_B, 8'h00);
        rchk("init_frozen", `HSSC_ADDR_CTRL_B, 8'h11);
        foreach (fm[i]) begin
            mode <= fm[i];
            step(3);
            chk("fault_out", 8'h00, {4'h0, outs});
            mode <= HSSC_MODE_NORMAL;
            step(3);
        end
        wr(`HSSC_ADDR_CTRL_A, 8'h11);
        wr(`HSSC_ADDR_CTRL_B, 8'h11);
        ov <= 1'b1;
        step(6);
        chk("ov_off", 8'h00, {4'h0, outs});
        ov <= 1'b0;
        step(6);
        chk("ov_back", 8'h0f, {4'h0, outs});
        // Recovery off: a passing undervoltage must leave everything cleared
        wr(`HSSC_ADDR_SUPPLY_CFG, 8'h03);
        uv <= 1'b1;
        step(6);
        uv <= 1'b0;
        step(6);
        chk("uv_stay_off", 8'h00, {4'h0, outs});
        rchk("ctrl_cleared", `HSSC_ADDR_CTRL_B, 8'h00);
        wr(`HSSC_ADDR_SUPPLY_CFG, 8'h01);
        wr(`HSSC_ADDR_CTRL_A, 8'h11);
        uv <= 1'b1;
        step(6);
        chk("uv_ignored", 8'h03, {4'h0, outs});
        uv <= 1'b0;
        rchk("irq_stat", `HSSC_ADDR_IRQ_STAT, 8'h0c);
        wr(`HSSC_ADDR_IRQ_STAT, 8'h0f);
        wr(`HSSC_ADDR_IRQ_MASK, 8'h01);
        short_m <= 4'h1;
        step(8);
        chk("oc_off", 8'h02, {4'h0, outs});
        chk("irq_raised", 8'h01, {7'h0, irq});
        short_m <= 4'h0;
        rchk("oc_flag", `HSSC_ADDR_OC_STAT, 8'h01);
        rchk("oc_cfg", `HSSC_ADDR_CTRL_A, 8'h10);
        wr(`HSSC_ADDR_IRQ_MASK, 8'h00);
        step(2);
        chk("irq_masked", 8'h00, {7'h0, irq});
        wr(`HSSC_ADDR_IRQ_MASK, 8'h01);
        wr(`HSSC_ADDR_OC_STAT, 8'h01);
        wr(`HSSC_ADDR_IRQ_STAT, 8'h0f);
        step(2);
        chk("irq_cleared", 8'h00, {7'h0, irq});
        rchk("oc_clear", `HSSC_ADDR_OC_STAT, 8'h00);
        // Channel 2 is off, so its open load must not be flagged
        open_m <= 4'h6;
        step(6);
        rchk("ol_flag", `HSSC_ADDR_OL_STAT, 8'h02);
        chk("ol_stays_on", 8'h02, {4'h0, outs});
        open_m <= 4'h0;
        // Let the cleared sense pass the synchroniser, or the set beats the clear
        step(4);
        wr(`HSSC_ADDR_OL_STAT, 8'h0f);
        rchk("ol_clear", `HSSC_ADDR_OL_STAT, 8'h00);
        wr(`HSSC_ADDR_PWM1, 8'h80);
        wr(`HSSC_ADDR_PWM2, 8'h40);
        wr(`HSSC_ADDR_PWM_FREQ, 8'h02);
        wr(`HSSC_ADDR_CTRL_A, 8'h32);
        wr(`HSSC_ADDR_CTRL_B, 8'h54);
        hi_cnt <= '{default: 0};
        counting <= 1'b1;
        step(4);
        edge_on <= 1'b1;
        step(WIN - 4);
        counting <= 1'b0;
        edge_on <= 1'b0;
        step(1);
        near("timer1", WIN / 10, hi_cnt[0]);
        near("timer2", WIN / 10, hi_cnt[1]);
        near("pwm1_200", WIN * 128 / 256, hi_cnt[2]);
        near("pwm2_400", WIN * 64 / 256, hi_cnt[3]);
        chk("pwm1_slow", 8'h01, {7'h0, rise_cnt[0] <= 1});
        chk("pwm2_fast", 8'h01, {7'h0, rise_cnt[1] >= 2});
        complete_run();
    end
endmodule // tb_top

bind hssc_core hssc_core_checker #(.N_CH(N_CH)) i_hssc_core_checker (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_mode(i_mode), .i_req(i_req),
    .i_sense(i_sense), .o_rdata(o_rdata), .o_switched_output_n(o_switched_output_n),
    .o_irq(o_irq));
